// *** verilog/ifr_device.sv ***
// Purpose: Receiver end: register file, one-shot init controller, datapath.
// Assumes: Serial pins arrive asynchronously and are synchronised here.
// Notes:   Contains the sample FIFO as a module of its own.
// What this block does
// - IF center held at 0x102/0x103.
// - Pass-band width held at 0x104/0x105.
// - Modulator clock rate held at 0x100/0x101.
// - Inductor value held at 0x106.
// - Resonator margin spans 0x107 to 0x109.
// - Feedback DAC full scale at 0x10A.
// - Controller runs regulator, calibration, tuning, PLL.
// - Controller disabled after initialization completes.
// - Quantizer code -8..+8 as five-bit word.
// - Shuffler rotates quantizer element selection.
// - Downconverter shifts pass band to zero.
// - Decimation factor 12, 16, 24 or 32.
// - 16-bit I/Q over one or two lanes.
// - Monitor peak or rms-like decimated power.
// - Thresholded level flags on four pins.
// - Attenuator 27 dB span, 1 dB steps.
// - Full scale reducible by at most 12 dB.
// - Synthesized clock 2.94 to 3.2 GHz.
// - Modulator clock within 2.0 to 3.2 GHz.
`include "ifr_regs.svh"
`default_nettype none

// ****************************************************************
// Sample FIFO
// ****************************************************************
module ifr_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;

  assign in_ready_o  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      wr_q <= '0;
    else if (in_valid_i && in_ready_o)
      wr_q <= wr_q + 1'b1;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      rd_q <= '0;
    else if (out_valid_o && out_ready_i)
      rd_q <= rd_q + 1'b1;

  always_ff @(posedge clk_i)
    if (in_valid_i && in_ready_o)
      mem_q[wr_q[AW-1:0]] <= in_data_i;
endmodule : ifr_fifo

// ****************************************************************
// Receiver end
// ****************************************************************
module ifr_device #(
  parameter int STEP_NS    = `IFR_STEP_NS,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Link to the host
  ifr_link_if.dev          link,
  // Flash quantizer stream
  input  wire logic [4:0]  quant_code_i,
  input  wire logic        quant_valid_i,
  output logic             quant_ready_o,
  // Analog control
  output logic [3:0]       init_stage_o,
  output logic [3:0]       shuffle_ptr_o,
  output logic [4:0]       atten_o,
  output logic [3:0]       fs_reduce_o,
  output logic [3:0]       gain_flag_o
);
  localparam int STEP_CYC_I = (STEP_NS * `IFR_CLK_MHZ + 999) / 1000;
  localparam int STEP_CYC   = STEP_CYC_I < 1 ? 1 : STEP_CYC_I;

  function automatic ifr_pkg::ifr_byte_t clamp(ifr_pkg::ifr_byte_t v,
                                               ifr_pkg::ifr_byte_t mx);
    return (v > mx) ? mx : v;
  endfunction : clamp

  // Lower address is the low byte.
  function automatic logic [15:0] pair(ifr_pkg::ifr_byte_t lo,
                                       ifr_pkg::ifr_byte_t hi);
    return {hi, lo};
  endfunction : pair

  // ****************************************************************
  // Serial port
  // ****************************************************************
  logic [2:0]  sclk_s;
  logic [1:0]  csb_s;
  logic [1:0]  sdi_s;
  logic [4:0]  bit_q;
  logic [15:0] cmd_q;
  logic [6:0]  dat_q;
  logic [7:0]  rd_sh_q;
  logic        sdo_q;
  logic        rd_en_q;
  logic        rise;
  logic        fall;
  logic [`IFR_ADDR_W-1:0] addr;
  logic        wr_stb;
  logic [7:0]  wr_dat;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      sclk_s <= '0;
      csb_s  <= 2'b11;
      sdi_s  <= '0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      csb_s  <= {csb_s[0], link.csb_n};
      sdi_s  <= {sdi_s[0], link.sdi};
    end

  assign rise   = sclk_s[1] & ~sclk_s[2] & ~csb_s[1];
  assign fall   = ~sclk_s[1] & sclk_s[2] & ~csb_s[1];
  assign addr   = cmd_q[`IFR_ADDR_W-1:0];
  assign wr_stb = rise && bit_q == 5'(`IFR_XFER_BITS - 1) && !cmd_q[15];
  assign wr_dat = {dat_q, sdi_s[1]};

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      bit_q <= '0;
      cmd_q <= '0;
      dat_q <= '0;
    end
    else if (csb_s[1])
      bit_q <= '0;
    else if (rise)
    begin
      bit_q <= bit_q + 1'b1;
      dat_q <= {dat_q[5:0], sdi_s[1]};
      // The command word freezes after 16 bits so the address survives.
      if (bit_q < 5'(`IFR_CMD_BITS))
        cmd_q <= {cmd_q[14:0], sdi_s[1]};
    end

  // ****************************************************************
  // Registers
  // ****************************************************************
  ifr_pkg::ifr_byte_t par_q [`IFR_PAR_N];
  ifr_pkg::ifr_byte_t dsp_q;
  ifr_pkg::ifr_byte_t atten_q;
  ifr_pkg::ifr_byte_t fsred_q;
  ifr_pkg::ifr_byte_t thr_hi_q;
  ifr_pkg::ifr_byte_t thr_lo_q;
  ifr_pkg::ifr_init_e st_q;
  logic               range_err_q;
  logic               go;

  // Parameter bytes are plain storage at 0x100 upward.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      par_q <= '{default: '0};
    else if (wr_stb && addr >= `IFR_A_RATE0 && addr <= `IFR_A_IDAC)
      par_q[4'(addr - `IFR_A_RATE0)] <= wr_dat;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      dsp_q    <= `IFR_DSP_RST;
      atten_q  <= '0;
      fsred_q  <= '0;
      thr_hi_q <= `IFR_THR_HI_RST;
      thr_lo_q <= `IFR_THR_LO_RST;
    end
    else if (wr_stb)
      unique case (addr)
        `IFR_A_DSP:    dsp_q    <= wr_dat;
        `IFR_A_ATTEN:  atten_q  <= clamp(wr_dat, `IFR_ATTEN_MAX);
        `IFR_A_FSRED:  fsred_q  <= clamp(wr_dat, `IFR_FSRED_MAX);
        `IFR_A_THR_HI: thr_hi_q <= wr_dat;
        `IFR_A_THR_LO: thr_lo_q <= wr_dat;
        default:       ;
      endcase

  assign go = wr_stb && addr == `IFR_A_INIT && wr_dat[`IFR_INIT_GO];

  function automatic ifr_pkg::ifr_byte_t rd_mux(logic [14:0] a);
    if (a >= `IFR_A_RATE0 && a <= `IFR_A_IDAC)
      return par_q[4'(a - `IFR_A_RATE0)];
    unique case (a)
      `IFR_A_STAT:   return {5'h00, range_err_q, st_q == ifr_pkg::INIT_DONE,
                             st_q != ifr_pkg::INIT_IDLE &&
                             st_q != ifr_pkg::INIT_DONE};
      `IFR_A_DSP:    return dsp_q;
      `IFR_A_ATTEN:  return atten_q;
      `IFR_A_FSRED:  return fsred_q;
      `IFR_A_THR_HI: return thr_hi_q;
      `IFR_A_THR_LO: return thr_lo_q;
      default:       return 8'h00;
    endcase
  endfunction : rd_mux

  // The first read bit leaves on the last command bit's rising edge, the rest on falling edges so the host sees them settled.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rd_en_q <= 1'b0;
      rd_sh_q <= '0;
      sdo_q   <= 1'b0;
    end
    else if (csb_s[1])
      rd_en_q <= 1'b0;
    else if (rise && bit_q == 5'(`IFR_CMD_BITS - 1) && cmd_q[14])
    begin
      rd_en_q <= 1'b1;
      {sdo_q, rd_sh_q} <= {rd_mux({cmd_q[13:0], sdi_s[1]}), 1'b0};
    end
    else if (fall && rd_en_q && bit_q >= 5'(`IFR_CMD_BITS + 1))
      {sdo_q, rd_sh_q} <= {rd_sh_q, 1'b0};

  assign link.sdo_out  = sdo_q;
  assign link.sdo_oe_n = ~rd_en_q;

  // ****************************************************************
  // One-shot initialization controller
  // ****************************************************************
  logic [15:0] step_q;
  logic [15:0] rate;
  logic        step_end;

  assign rate     = pair(par_q[0], par_q[1]);
  assign step_end = step_q == 16'(STEP_CYC - 1);

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      step_q <= '0;
    else if (st_q == ifr_pkg::INIT_IDLE || st_q == ifr_pkg::INIT_DONE
             || step_end)
      step_q <= '0;
    else
      step_q <= step_q + 1'b1;

  // DONE is terminal: a second start is ignored until reset.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      st_q <= ifr_pkg::INIT_IDLE;
    else
      unique case (st_q)
        ifr_pkg::INIT_IDLE:  if (go) st_q <= ifr_pkg::INIT_REGUP;
        ifr_pkg::INIT_REGUP: if (step_end) st_q <= ifr_pkg::INIT_CAL;
        ifr_pkg::INIT_CAL:   if (step_end) st_q <= ifr_pkg::INIT_TUNE;
        ifr_pkg::INIT_TUNE:  if (step_end) st_q <= ifr_pkg::INIT_PLL;
        ifr_pkg::INIT_PLL:   if (step_end) st_q <= ifr_pkg::INIT_DONE;
        ifr_pkg::INIT_DONE:  st_q <= ifr_pkg::INIT_DONE;
      endcase

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      range_err_q <= 1'b0;
    else if (st_q == ifr_pkg::INIT_TUNE && step_end)
      range_err_q <= rate < `IFR_RATE_MIN || rate > `IFR_RATE_MAX
        || (dsp_q[`IFR_DSP_SYNTH] && rate < `IFR_SYNTH_MIN);

  assign init_stage_o = {st_q == ifr_pkg::INIT_PLL,
                         st_q == ifr_pkg::INIT_TUNE,
                         st_q == ifr_pkg::INIT_CAL,
                         st_q == ifr_pkg::INIT_REGUP};
  assign atten_o      = atten_q[4:0];
  assign fs_reduce_o  = fsred_q[3:0];

  // ****************************************************************
  // Datapath
  // ****************************************************************
  logic signed [4:0]  code;
  logic signed [15:0] acc_i_q;
  logic signed [15:0] acc_q_q;
  logic signed [15:0] mix_i;
  logic signed [15:0] mix_q;
  logic signed [15:0] sum_i;
  logic signed [15:0] sum_q;
  logic [15:0] phase_q;
  logic [4:0]  cnt_q;
  logic [4:0]  deci_last;
  logic [3:0]  peak_q;
  logic        ovl_q;
  logic [3:0]  mag;
  logic        take;
  logic        last;
  logic        fifo_ready;
  logic        fifo_valid;
  logic        beat_q;
  logic [7:0]  level;
  ifr_pkg::ifr_iq_s push_iq;
  ifr_pkg::ifr_iq_s pop_iq;

  // Codes outside -8..+8 are clamped to the nearest legal level.
  always_comb
  begin
    code = $signed(quant_code_i);
    if (code > `IFR_CODE_MAX)
      code = `IFR_CODE_MAX;
    else if (code < -`IFR_CODE_MAX)
      code = -`IFR_CODE_MAX;
  end

  assign mag = code[4] ? 4'(-code) : 4'(code);

  // Quarter-cycle rotation steered by the IF-center phase word.
  always_comb
    unique case (phase_q[15:14])
      2'd0: {mix_i, mix_q} = {16'(code), 16'sh0000};
      2'd1: {mix_i, mix_q} = {16'sh0000, 16'(-code)};
      2'd2: {mix_i, mix_q} = {16'(-code), 16'sh0000};
      2'd3: {mix_i, mix_q} = {16'sh0000, 16'(code)};
    endcase

  always_comb
    unique case (dsp_q[`IFR_DSP_DECI])
      2'd0: deci_last = 5'd11;
      2'd1: deci_last = 5'd15;
      2'd2: deci_last = 5'd23;
      2'd3: deci_last = 5'd31;
    endcase

  assign quant_ready_o = fifo_ready && st_q == ifr_pkg::INIT_DONE;
  assign take          = quant_valid_i && quant_ready_o;
  assign last          = cnt_q >= deci_last;
  assign sum_i         = acc_i_q + mix_i;
  assign sum_q         = acc_q_q + mix_q;
  assign push_iq       = '{i: sum_i <<< 6, q: sum_q <<< 6};

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_q   <= '0;
      acc_i_q <= '0;
      acc_q_q <= '0;
      phase_q <= '0;
    end
    else if (take)
    begin
      cnt_q   <= last ? 5'd0 : cnt_q + 1'b1;
      acc_i_q <= last ? 16'sh0000 : sum_i;
      acc_q_q <= last ? 16'sh0000 : sum_q;
      phase_q <= phase_q + pair(par_q[2], par_q[3]);
    end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      shuffle_ptr_o <= '0;
    else if (take && dsp_q[`IFR_DSP_SHUF])
      shuffle_ptr_o <= shuffle_ptr_o + mag;

  // Level is block peak, or |I|+|Q| of the decimated word.
  assign level = dsp_q[`IFR_DSP_RMS]
    ? 8'((sum_i[15] ? -sum_i : sum_i) + (sum_q[15] ? -sum_q : sum_q))
    : {peak_q > mag ? peak_q : mag, 4'h0};

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      peak_q <= '0;
      ovl_q  <= 1'b0;
    end
    else if (take)
    begin
      peak_q <= last ? 4'h0 : (peak_q > mag ? peak_q : mag);
      ovl_q  <= last ? 1'b0 : (ovl_q || mag == 4'd8);
    end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      gain_flag_o <= '0;
    else if (take && last)
      gain_flag_o <= {ovl_q || mag == 4'd8,
                      level <= thr_hi_q && level >= thr_lo_q,
                      level < thr_lo_q,
                      level > thr_hi_q};

  ifr_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (take && last),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_iq),
    .out_valid_o (fifo_valid),
    .out_ready_i (link.lane_ready && (dsp_q[`IFR_DSP_DUAL] || beat_q)),
    .out_data_o  (pop_iq)
  );

  // One lane carries I then Q; two lanes carry both in one beat.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      beat_q <= 1'b0;
    else if (dsp_q[`IFR_DSP_DUAL])
      beat_q <= 1'b0;
    else if (fifo_valid && link.lane_ready)
      beat_q <= ~beat_q;

  assign link.lane_valid = fifo_valid;
  assign link.lane0      = (beat_q && !dsp_q[`IFR_DSP_DUAL]) ? pop_iq.q
                                                             : pop_iq.i;
  assign link.lane1      = dsp_q[`IFR_DSP_DUAL] ? pop_iq.q : 16'h0000;
endmodule : ifr_device
`default_nettype wire

// *** verilog/ifr_regs.svh ***
// Purpose: Register offsets, field positions and timing counts.
// Assumes: Byte-wide registers behind a 15-bit serial register address.
// Notes:   Included by both ends of the receiver configuration link.
`ifndef IFR_REGS_SVH
`define IFR_REGS_SVH

// ****************************************************************
// Application parameter registers
// ****************************************************************
`define IFR_ADDR_W      15
`define IFR_A_RATE0     15'h0100
`define IFR_A_RATE1     15'h0101
`define IFR_A_IFC0      15'h0102
`define IFR_A_IFC1      15'h0103
`define IFR_A_BW0       15'h0104
`define IFR_A_BW1       15'h0105
`define IFR_A_EXT_INDUCTOR_VALUE      15'h0106
`define IFR_A_MRGN0     15'h0107
`define IFR_A_MRGN2     15'h0109
`define IFR_A_IDAC      15'h010a
`define IFR_PAR_N       11

// ****************************************************************
// Control and status registers
// ****************************************************************
`define IFR_A_INIT      15'h0110
`define IFR_A_STAT      15'h0111
`define IFR_A_DSP       15'h0112
`define IFR_A_ATTEN     15'h0113
`define IFR_A_FSRED     15'h0114
`define IFR_A_THR_HI    15'h0115
`define IFR_A_THR_LO    15'h0116
`define IFR_INIT_GO     0
`define IFR_ST_BUSY     0
`define IFR_ST_DONE     1
`define IFR_ST_RANGE    2
`define IFR_DSP_DECI    1:0
`define IFR_DSP_DUAL    2
`define IFR_DSP_SHUF    3
`define IFR_DSP_RMS     4
`define IFR_DSP_SYNTH   5
`define IFR_DSP_RST     8'h28
`define IFR_THR_HI_RST  8'hc0
`define IFR_THR_LO_RST  8'h10

// ****************************************************************
// Limits and timing
// ****************************************************************
`define IFR_ATTEN_MAX   8'd27
`define IFR_FSRED_MAX   8'd12
`define IFR_RATE_MIN    16'd2000
`define IFR_RATE_MAX    16'd3200
`define IFR_SYNTH_MIN   16'd2940
`define IFR_CODE_MAX    5'sd8
`define IFR_CLK_MHZ     25
`define IFR_STEP_NS     2000
`define IFR_SPI_HALF    8
`define IFR_CMD_BITS    16
`define IFR_XFER_BITS   24
`endif

// *** verilog/ifr_pkg.sv ***
// Purpose: Shared types of the receiver configuration link.
// Assumes: Constants come from ifr_regs.svh.
// Notes:   Nothing here is imported; users write ifr_pkg::name.
`default_nettype none
package ifr_pkg;
  typedef logic [7:0] ifr_byte_t;
  typedef enum logic [2:0] {
    INIT_IDLE, INIT_REGUP, INIT_CAL, INIT_TUNE, INIT_PLL, INIT_DONE
  } ifr_init_e;
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } ifr_iq_s;
endpackage : ifr_pkg
`default_nettype wire

// *** verilog/ifr_link_if.sv ***
// Purpose: Serial register port and sample lanes between the two ends.
// Assumes: One system clock drives both ends.
// Notes:   The read-data pin floats high when nobody drives it.
`default_nettype none
interface ifr_link_if;
  logic        sclk;
  logic        csb_n;
  logic        sdi;
  logic        sdo_out;
  logic        sdo_oe_n;
  wire  logic  sdo;
  logic [15:0] lane0;
  logic [15:0] lane1;
  logic        lane_valid;
  logic        lane_ready;

  assign sdo = sdo_oe_n ? 1'b1 : sdo_out;

  modport dev (
    input  sclk, csb_n, sdi, lane_ready,
    output sdo_out, sdo_oe_n, lane0, lane1, lane_valid
  );
  modport host (
    input  sdo, lane0, lane1, lane_valid,
    output sclk, csb_n, sdi, lane_ready
  );
endinterface : ifr_link_if
`default_nettype wire

// *** verilog/ifr_host.sv ***
// Purpose: Host end: serial register master and sample lane receiver.
// Assumes: Serial clock derived from the system clock by a divider.
// Notes:   Caller must write every parameter byte before starting init.
`include "ifr_regs.svh"
`default_nettype none
module ifr_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Link to the receiver
  ifr_link_if.host         link,
  // Register command port
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [14:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_wdata_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_rdata_o,
  // Sample output
  input  wire logic        dual_lane_i,
  input  wire logic        iq_ready_i,
  output logic             iq_valid_o,
  output logic [15:0]      iq_i_o,
  output logic [15:0]      iq_q_o
);
  // ****************************************************************
  // Serial master
  // ****************************************************************
  logic [23:0] sh_q;
  logic [7:0]  rx_q;
  logic [4:0]  bit_q;
  logic [4:0]  div_q;
  logic        busy_q;
  logic        sclk_q;
  logic [1:0]  sdo_s;
  logic        bit_end;

  assign cmd_ready_o = ~busy_q;
  assign bit_end     = div_q == 5'(2 * `IFR_SPI_HALF - 1);

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      sdo_s <= '0;
    else
      sdo_s <= {sdo_s[0], link.sdo};

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      busy_q <= 1'b0;
      sh_q   <= '0;
      bit_q  <= '0;
      div_q  <= '0;
      sclk_q <= 1'b0;
    end
    else if (!busy_q)
    begin
      if (cmd_valid_i)
      begin
        busy_q <= 1'b1;
        sh_q   <= {~cmd_write_i, cmd_addr_i, cmd_wdata_i};
        bit_q  <= '0;
        div_q  <= '0;
      end
    end
    else
    begin
      div_q  <= bit_end ? 5'd0 : div_q + 1'b1;
      sclk_q <= div_q == 5'(`IFR_SPI_HALF - 1) ? 1'b1
              : (bit_end ? 1'b0 : sclk_q);
      if (bit_end)
      begin
        sh_q  <= {sh_q[22:0], 1'b0};
        bit_q <= bit_q + 1'b1;
        if (bit_q == 5'(`IFR_XFER_BITS - 1))
          busy_q <= 1'b0;
      end
    end

  // Sample just before the rising edge; data changed a half period ago.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      rx_q <= '0;
    else if (busy_q && div_q == 5'(`IFR_SPI_HALF - 1))
      rx_q <= {rx_q[6:0], sdo_s[1]};

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      rsp_valid_o <= 1'b0;
    else
      rsp_valid_o <= busy_q && bit_end && bit_q == 5'(`IFR_XFER_BITS - 1);

  assign rsp_rdata_o = rx_q;
  assign link.sclk   = sclk_q;
  assign link.csb_n  = ~busy_q;
  assign link.sdi    = sh_q[23];

  // ****************************************************************
  // Sample receiver
  // ****************************************************************
  logic        half_q;
  logic [15:0] i_hold_q;
  logic        take;

  assign link.lane_ready = ~iq_valid_o || iq_ready_i;
  assign take            = link.lane_valid && link.lane_ready;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      half_q   <= 1'b0;
      i_hold_q <= '0;
    end
    else if (take && !dual_lane_i)
    begin
      half_q <= ~half_q;
      if (!half_q)
        i_hold_q <= link.lane0;
    end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      iq_valid_o <= 1'b0;
      iq_i_o     <= '0;
      iq_q_o     <= '0;
    end
    else if (take && (dual_lane_i || half_q))
    begin
      iq_valid_o <= 1'b1;
      iq_i_o     <= dual_lane_i ? link.lane0 : i_hold_q;
      iq_q_o     <= dual_lane_i ? link.lane1 : link.lane0;
    end
    else if (iq_ready_i)
      iq_valid_o <= 1'b0;
endmodule : ifr_host
`default_nettype wire

// *** sim/ifr_link_monitor.sv ***
// Purpose: Assertions on the serial frame and the sample lanes.
// Assumes: One clock; rst_i is high while resetting.
// Notes:   Instantiated beside the link interface.
`default_nettype none
module ifr_link_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Link
  input wire logic        sclk,
  input wire logic        csb_n,
  input wire logic        sdi,
  input wire logic        sdo_oe_n,
  input wire logic [15:0] lane0,
  input wire logic        lane_valid,
  input wire logic        lane_ready
);
  // ****************
  // Frame length
  // ****************
  logic [8:0] low_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      low_q <= 9'h000;
    else
      low_q <= csb_n ? 9'h000 : low_q + 9'h001;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ****************
  // Assertions
  // ****************
  frame_len_a: assert property ($rose(csb_n) |-> low_q == 9'h180)
    else $error("frame length");
  sdi_hold_a: assert property (sclk |-> $stable(sdi))
    else $error("sdi moved");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low");
  frame_start_a: assert property (
    $fell(csb_n) |-> !sclk [*8] ##1 sclk) else $error("frame start");
  oe_idle_a: assert property (csb_n [*6] |-> sdo_oe_n)
    else $error("sdo driven");
  idle_sclk_a: assert property (csb_n |-> !sclk)
    else $error("sclk idle");
  lane_hold_a: assert property (lane_valid && !lane_ready |=>
    lane_valid && $stable(lane0)) else $error("lane dropped");
  frame_c: cover property ($rose(csb_n));
  read_c: cover property ($fell(sdo_oe_n));
  stall_c: cover property (lane_valid && !lane_ready);
endmodule : ifr_link_monitor
`default_nettype wire

// *** sim/test_if_receiver_config_init.sv ***
// Purpose: Runs both ends through the host command port.
// Assumes: Init stages shortened to 200 ns.
// Notes:   Expected results wait in queues for the outputs.
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t mismatch %h %h", $time, a, b); end end
module test_if_receiver_config_init;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i = 1'b1, cv = 1'b0, cw = 1'b0, crdy, rv;
  logic        qv = 1'b0, qrdy, ir = 1'b0, iv, dl = 1'b0;
  logic [3:0]  ist, shp, fsr, gf;
  logic [14:0] ca = 15'h0000;
  logic [7:0]  cd = 8'h00, rdat, pv[11];
  logic [4:0]  qc = 5'h00, att;
  logic [15:0] ii, iq;
  logic [8:0]  rq[$];
  logic [31:0] iqq[$];
  int          n_fail, cmp_count, n;
  localparam logic [14:0] RA[6] = '{15'h0112, 15'h0115, 15'h0116,
                                    15'h0111, 15'h0100, 15'h0120};
  localparam logic [7:0] RV[6] = '{8'h28, 8'hc0, 8'h10, 8'h00, 8'h00, 8'h00};
  ifr_link_if ifr_link_if_inst ();
  ifr_device #(.STEP_NS(200), .FIFO_DEPTH(16)) ifr_device_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link(ifr_link_if_inst),
    .quant_code_i(qc), .quant_valid_i(qv), .quant_ready_o(qrdy),
    .init_stage_o(ist), .shuffle_ptr_o(shp), .atten_o(att),
    .fs_reduce_o(fsr), .gain_flag_o(gf));
  ifr_host ifr_host_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link(ifr_link_if_inst),
    .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_wdata_i(cd),
    .cmd_ready_o(crdy), .rsp_valid_o(rv), .rsp_rdata_o(rdat),
    .dual_lane_i(dl), .iq_ready_i(ir), .iq_valid_o(iv), .iq_i_o(ii),
    .iq_q_o(iq));
  ifr_link_monitor ifr_link_monitor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .sclk(ifr_link_if_inst.sclk),
    .csb_n(ifr_link_if_inst.csb_n), .sdi(ifr_link_if_inst.sdi),
    .sdo_oe_n(ifr_link_if_inst.sdo_oe_n), .lane0(ifr_link_if_inst.lane0),
    .lane_valid(ifr_link_if_inst.lane_valid),
    .lane_ready(ifr_link_if_inst.lane_ready));
  // ****************
  // Drivers
  // ****************
  task automatic cmd(input logic w, input logic [14:0] a, input logic [7:0] d,
                     input logic [8:0] e);
    @(posedge clk_i);
    cv <= 1'b1;
    cw <= w;
    ca <= a;
    cd <= d;
    @(negedge clk_i);
    while (crdy !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    rq.push_back(e);
    cv <= 1'b0;
  endtask : cmd
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    cmd(1'b1, a, d, 9'h000);
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [7:0] v);
    cmd(1'b0, a, 8'h00, {1'b1, v});
  endtask : rd
  // Each sample is held until the edge that takes it.
  task automatic feed(input int cnt, input logic [4:0] c);
    repeat (cnt)
    begin
      @(posedge clk_i);
      qv <= 1'b1;
      qc <= c;
      @(negedge clk_i);
      while (qrdy !== 1'b1) @(negedge clk_i);
    end
    @(posedge clk_i);
    qv <= 1'b0;
  endtask : feed
  task automatic drain;
    while (rq.size() != 0 || iqq.size() != 0) @(posedge clk_i);
  endtask : drain
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // ****************
  // Checkers
  // ****************
  always @(posedge clk_i)
  begin
    if (rv === 1'b1 && rq.size() != 0)
    begin
      if (rq[0][8]) `CHK(rdat, rq[0][7:0])
      void'(rq.pop_front());
    end
    if (iv === 1'b1 && ir === 1'b1 && iqq.size() != 0)
    begin
      `CHK({ii, iq}, iqq[0])
      void'(iqq.pop_front());
    end
  end
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h09f9));
    foreach (pv[k]) pv[k] = 8'($urandom());
    pv[0] = 8'h80;
    pv[1] = 8'h0c;
    pv[2] = 8'h00;
    pv[3] = 8'h00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(qrdy, 1'b0)
    foreach (RA[k]) rd(RA[k], RV[k]);
    foreach (pv[k]) wr(15'h0100 + 15'(k), pv[k]);
    foreach (pv[k]) rd(15'h0100 + 15'(k), pv[k]);
    wr(15'h0113, 8'h1e);
    rd(15'h0113, 8'h1b);
    wr(15'h0114, 8'h0f);
    rd(15'h0114, 8'h0c);
    wr(15'h0110, 8'h01);
    rd(15'h0111, 8'h02);
    wr(15'h0110, 8'h01);
    rd(15'h0111, 8'h02);
    drain();
    `CHK(att, 5'h1b)
    `CHK(fsr, 4'hc)
    ir <= 1'b1;
    // Odd selections also use two lanes; the longest block measures rms.
    for (int d = 3; d >= 0; d--)
    begin
      wr(15'h0112, 8'h28 | 8'(d) | (d[0] ? 8'h04 : 8'h00)
                   | (d == 3 ? 8'h10 : 8'h00));
      dl <= d[0];
      drain();
      n = (d[0] ? 16 : 12) * (d[1] ? 2 : 1);
      iqq.push_back({16'(n * 512), 16'h0000});
      feed(n, 5'h08);
      drain();
      `CHK(gf, (d == 3) ? 4'ha : 4'hc)
    end
    ir <= 1'b0;
    fork
      for (int k = 0; k < 20; k++)
      begin
        iqq.push_back({k[0] ? 16'he800 : 16'h1800, 16'h0000});
        feed(12, k[0] ? 5'h18 : 5'h0f);
      end
      begin
        repeat (600) @(posedge clk_i);
        `CHK(qrdy, 1'b0)
        ir <= 1'b1;
      end
    join
    drain();
    // A quarter-turn phase step cancels a constant input over whole turns.
    wr(15'h0103, 8'h40);
    drain();
    iqq.push_back(32'h0000_0000);
    feed(12, 5'h08);
    drain();
    `CHK(gf, 4'hc)
    `CHK(shp, 4'h0)
    `CHK(ist, 4'h0)
    give_verdict();
  end
endmodule : test_if_receiver_config_init
`default_nettype wire
